// >>> rtl/btd_cfg.svh
// Constants of the bundle template decoder: field positions, codes, timing.
// Assumes bundles arrive as 16 bytes, byte 0 in bits 7:0.
`ifndef BTD_CFG_SVH
`define BTD_CFG_SVH

// Bundle geometry
`define BTD_BUNDLE_W    128
`define BTD_BUNDLE_BYTES 16
`define BTD_ADDR_W      64
`define BTD_ALIGN_BITS  4
`define BTD_TMPL_W      5
`define BTD_SLOT_W      41
`define BTD_TMPL_LSB    0
`define BTD_SLOT0_LSB   5
`define BTD_SLOT1_LSB   46
`define BTD_SLOT2_LSB   87
`define BTD_OPC_MSB     40
`define BTD_OPC_LSB     37

// Template codes
`define BTD_TMPL_MII_FIRST  5'h00
`define BTD_TMPL_MII_STOP12 5'h03
`define BTD_TMPL_MLX_FIRST  5'h04
`define BTD_TMPL_MLX_LAST   5'h05
`define BTD_TMPL_MMI_FIRST  5'h08
`define BTD_TMPL_MMI_LAST   5'h0A

// Major opcode codes
`define BTD_ALU_OPC_MIN  4'h8
`define BTD_XBR_OPC_A    4'hC
`define BTD_XBR_OPC_B    4'hD

// Reset value of ready, and phase count
`define BTD_RST_READY    1'b1
`define BTD_PHASES       4

`endif

// >>> rtl/btd_decoder.sv
// Bundle template decoder: splits bundles into slots, maps units, issues in order.
// Assumes fetch presents one bundle at a time with a valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
`include "btd_cfg.svh"

// Notes on behaviour
// - Accept aligned 16-byte bundles only
// - Split into template and three slots
// - Little-endian bundle, template in byte 0
// - Data endian select never affects decode
// - Template 00 no stops; 03 two
// - Map slots to units by template
// - Classify instruction into six types
// - Extended spans two slots, opcode picks unit
// - Bundles issued in arrival address order
// - Slots issued 0 through 2
// - Stops flagged to issue logic
// - Fetch then read phases
// - Execute then update phases
// - Group ends at stop
module btd_decoder
  import btd_pkg::*;
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  // Bundle from fetch
  input  wire logic                      bundle_valid,
  input  wire logic [`BTD_BUNDLE_W-1:0]  bundle_data,
  input  wire logic [`BTD_ADDR_W-1:0]    bundle_addr,
  output logic                           bundle_ready_ff,
  // Mode input, deliberately unused by decode
  input  wire logic                      data_big_endian_select,
  // Issue to execution units
  output btd_issue_s                     issue_ff,
  output logic                           group_end_ff,
  output logic [`BTD_PHASES-1:0]         phase_ff,
  // Error pulses
  output logic                           misaligned_ff,
  output logic                           illegal_tmpl_ff
);

  // ----------------------------------------------------------------
  // Held bundle and sequencer state
  // ----------------------------------------------------------------
  btd_state_e                  state_ff;      // Sequencer state
  btd_state_e                  nxt_state;
  logic [`BTD_BUNDLE_W-1:0]    bundle_ff;     // Bundle under issue
  logic [`BTD_BUNDLE_W-1:0]    nxt_bundle;
  logic [`BTD_ADDR_W-1:0]      addr_ff;       // Its address
  logic [`BTD_ADDR_W-1:0]      nxt_addr;
  logic [1:0]                  slot_ff;       // Next slot to issue
  logic [1:0]                  nxt_slot;
  logic                        nxt_ready;
  btd_issue_s                  nxt_issue;
  logic                        nxt_group_end;
  logic [`BTD_PHASES-1:0]      nxt_phase;
  logic                        nxt_misaligned;
  logic                        nxt_illegal;

  // Decoded fields of the held bundle
  logic [`BTD_TMPL_W-1:0]      tmpl;          // Template field
  logic [`BTD_SLOT_W-1:0]      slot_word [3]; // Three slots
  btd_unit_e                   slot_unit [3]; // Unit per slot
  logic [2:0]                  stop_after;    // Stop after slot n
  logic                        accept;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  // Byte 0 is bits 7:0 whatever the data byte order; instructions are
  // always little-endian so the endian select is never consulted.
  assign tmpl = bundle_ff[`BTD_TMPL_LSB +: `BTD_TMPL_W];
  assign slot_word[0] = bundle_ff[`BTD_SLOT0_LSB +: `BTD_SLOT_W];
  assign slot_word[1] = bundle_ff[`BTD_SLOT1_LSB +: `BTD_SLOT_W];
  assign slot_word[2] = bundle_ff[`BTD_SLOT2_LSB +: `BTD_SLOT_W];

  // Take a bundle only while idle and advertising ready
  assign accept = bundle_valid && bundle_ready_ff;

  // ----------------------------------------------------------------
  // Template to units and stops
  // ----------------------------------------------------------------
  // Unlisted templates decode to no unit so nothing is dispatched.
  always_comb begin
    slot_unit[0] = BTD_UNIT_NONE;
    slot_unit[1] = BTD_UNIT_NONE;
    slot_unit[2] = BTD_UNIT_NONE;
    stop_after   = 3'b000;
    if (tmpl <= `BTD_TMPL_MII_STOP12) begin
      slot_unit[0] = BTD_UNIT_M;
      slot_unit[1] = BTD_UNIT_I;
      slot_unit[2] = BTD_UNIT_I;
    end else if (tmpl >= `BTD_TMPL_MLX_FIRST && tmpl <= `BTD_TMPL_MLX_LAST) begin
      slot_unit[0] = BTD_UNIT_M;
      slot_unit[1] = BTD_UNIT_L;
      slot_unit[2] = BTD_UNIT_X;
    end else if (tmpl >= `BTD_TMPL_MMI_FIRST && tmpl <= `BTD_TMPL_MMI_LAST) begin
      slot_unit[0] = BTD_UNIT_M;
      slot_unit[1] = BTD_UNIT_M;
      slot_unit[2] = BTD_UNIT_I;
    end
    // Only the template 03 stop layout is encoded; others carry none
    if (tmpl == `BTD_TMPL_MII_STOP12) begin
      stop_after = 3'b110;
    end
  end

  // ----------------------------------------------------------------
  // Classification of one slot
  // ----------------------------------------------------------------
  // An integer or memory slot with a high major opcode is ALU work
  // that either unit could run.
  function automatic btd_itype_e btd_classify(input btd_unit_e unit,
                                              input logic [3:0] opc);
    btd_itype_e t;
    t = BTD_ITYPE_I;
    unique case (unit)
      BTD_UNIT_M: t = (opc >= `BTD_ALU_OPC_MIN) ? BTD_ITYPE_A : BTD_ITYPE_M;
      BTD_UNIT_I: t = (opc >= `BTD_ALU_OPC_MIN) ? BTD_ITYPE_A : BTD_ITYPE_I;
      BTD_UNIT_F: t = BTD_ITYPE_F;
      BTD_UNIT_B: t = BTD_ITYPE_B;
      BTD_UNIT_L: t = BTD_ITYPE_LX;
      BTD_UNIT_X: t = BTD_ITYPE_LX;
      default:    t = BTD_ITYPE_I;
    endcase
    return t;
  endfunction : btd_classify

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // One instruction leaves per cycle; a bundle is finished before the
  // next is taken, so issue order follows fetch address order.
  always_comb begin
    nxt_state      = state_ff;
    nxt_bundle     = bundle_ff;
    nxt_addr       = addr_ff;
    nxt_slot       = slot_ff;
    nxt_ready      = bundle_ready_ff;
    nxt_issue      = '0;
    nxt_group_end  = 1'b0;
    nxt_misaligned = 1'b0;
    nxt_illegal    = 1'b0;
    unique case (state_ff)
      // Wait for a bundle
      BTD_ST_IDLE: begin
        if (accept) begin
          if (bundle_addr[`BTD_ALIGN_BITS-1:0] != '0) begin
            // Straddling bundle: refused, never decoded
            nxt_misaligned = 1'b1;
          end else begin
            nxt_bundle = bundle_data;
            nxt_addr   = bundle_addr;
            nxt_slot   = 2'd0;
            nxt_state  = BTD_ST_ISSUE;
            nxt_ready  = 1'b0;
          end
        end
      end
      // Issue slots in ascending order
      BTD_ST_ISSUE: begin
        if (slot_unit[0] == BTD_UNIT_NONE) begin
          // Undefined template: drop the whole bundle
          nxt_illegal = 1'b1;
          nxt_state   = BTD_ST_IDLE;
          nxt_ready   = 1'b1;
        end else begin
          nxt_issue.valid = 1'b1;
          nxt_issue.slot  = slot_ff;
          nxt_issue.addr  = addr_ff;
          nxt_issue.insn  = {{`BTD_SLOT_W{1'b0}}, slot_word[slot_ff]};
          nxt_issue.unit  = slot_unit[slot_ff];
          nxt_issue.itype = btd_classify(slot_unit[slot_ff],
                              slot_word[slot_ff][`BTD_OPC_MSB:`BTD_OPC_LSB]);
          nxt_issue.stop  = stop_after[slot_ff];
          nxt_slot        = slot_ff + 2'd1;
          if (slot_unit[slot_ff] == BTD_UNIT_L) begin
            // Long form: slots 1 and 2 leave together as one instruction
            nxt_issue.insn     = {slot_word[2], slot_word[1]};
            nxt_issue.extended = 1'b1;
            nxt_issue.stop     = stop_after[2];
            nxt_issue.unit     =
              (slot_word[2][`BTD_OPC_MSB:`BTD_OPC_LSB] == `BTD_XBR_OPC_A ||
               slot_word[2][`BTD_OPC_MSB:`BTD_OPC_LSB] == `BTD_XBR_OPC_B)
              ? BTD_UNIT_B : BTD_UNIT_I;
            nxt_slot           = 2'd3;
          end
          nxt_group_end = nxt_issue.stop;
          if (nxt_slot == 2'd3) begin
            nxt_state = BTD_ST_IDLE;
            nxt_ready = 1'b1;
          end
        end
      end
      default: begin
        nxt_state = BTD_ST_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Phase tracker next value
  // ----------------------------------------------------------------
  // Bit 0 fetch, 1 read, 2 execute, 3 update: bit 0 marks a bundle taken; each issued
  // instruction walks bits 1 to 3 in order, one cycle apiece.
  always_comb begin
    nxt_phase    = {phase_ff[2], phase_ff[1], 1'b0, 1'b0};
    nxt_phase[0] = accept;
    nxt_phase[1] = nxt_issue.valid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff        <= BTD_ST_IDLE;
      bundle_ff       <= '0;
      addr_ff         <= '0;
      slot_ff         <= 2'd0;
      bundle_ready_ff <= `BTD_RST_READY;
      issue_ff        <= '0;
      group_end_ff    <= 1'b0;
      phase_ff        <= '0;
      misaligned_ff   <= 1'b0;
      illegal_tmpl_ff <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      bundle_ff       <= nxt_bundle;
      addr_ff         <= nxt_addr;
      slot_ff         <= nxt_slot;
      bundle_ready_ff <= nxt_ready;
      issue_ff        <= nxt_issue;
      group_end_ff    <= nxt_group_end;
      phase_ff        <= nxt_phase;
      misaligned_ff   <= nxt_misaligned;
      illegal_tmpl_ff <= nxt_illegal;
    end
  end

endmodule : btd_decoder
`default_nettype wire

// >>> rtl/btd_pkg.sv
// Types of the bundle template decoder.
// Assumes btd_cfg.svh supplies the widths.
`include "btd_cfg.svh"

package btd_pkg;

  // Execution unit types, one-hot
  typedef enum logic [5:0] {
    BTD_UNIT_NONE = 6'h00,
    BTD_UNIT_M    = 6'h01,
    BTD_UNIT_I    = 6'h02,
    BTD_UNIT_F    = 6'h04,
    BTD_UNIT_B    = 6'h08,
    BTD_UNIT_L    = 6'h10,
    BTD_UNIT_X    = 6'h20
  } btd_unit_e;

  // Instruction types
  typedef enum logic [2:0] {
    BTD_ITYPE_A   = 3'h0,
    BTD_ITYPE_I   = 3'h1,
    BTD_ITYPE_M   = 3'h2,
    BTD_ITYPE_F   = 3'h3,
    BTD_ITYPE_B   = 3'h4,
    BTD_ITYPE_LX  = 3'h5
  } btd_itype_e;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    BTD_ST_IDLE  = 2'b01,
    BTD_ST_ISSUE = 2'b10
  } btd_state_e;

  // One issued instruction
  typedef struct packed {
    logic                            valid;
    logic [2*`BTD_SLOT_W-1:0]        insn;
    logic [1:0]                      slot;
    btd_itype_e                      itype;
    btd_unit_e                       unit;
    logic                            stop;
    logic                            extended;
    logic [`BTD_ADDR_W-1:0]          addr;
  } btd_issue_s;

endpackage : btd_pkg

// >>> sim/btd_checker.sv
// Checker of the bundle decoder: handshake, issue order, phases, flags.
// Assumes it is bound to btd_decoder and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "btd_cfg.svh"

module btd_checker
  import btd_pkg::*;
(
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     reset,
  // Bundle port
  input wire logic                     bundle_valid,
  input wire logic [`BTD_BUNDLE_W-1:0] bundle_data,
  input wire logic [`BTD_ADDR_W-1:0]   bundle_addr,
  input wire logic                     bundle_ready_ff,
  input wire logic                     data_big_endian_select,
  // Issue side
  input wire btd_issue_s               issue_ff,
  input wire logic                     group_end_ff,
  input wire logic [`BTD_PHASES-1:0]   phase_ff,
  input wire logic                     misaligned_ff,
  input wire logic                     illegal_tmpl_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Helpers: accepted offer and template legality
  logic take;
  logic legal;
  assign take  = bundle_valid && bundle_ready_ff;
  assign legal = (bundle_data[4:0] <= 5'h05) ||
                 (bundle_data[4:0] >= 5'h08 && bundle_data[4:0] <= 5'h0A);

  sequence s_take_ok;
    take && bundle_addr[3:0] == 4'h0;
  endsequence
  sequence s_first_issue;
    issue_ff.valid && issue_ff.slot == 2'd0 && issue_ff.unit == BTD_UNIT_M;
  endsequence

  a_take_busy: assert property (s_take_ok |=> !bundle_ready_ff && phase_ff[0])
    else $error("aligned bundle did not lower ready");
  a_misalign_flag: assert property (take && bundle_addr[3:0] != 4'h0 |=>
    misaligned_ff && bundle_ready_ff) else $error("misaligned bundle not refused");
  a_first_issue: assert property (s_take_ok ##0 legal |-> ##2 s_first_issue)
    else $error("slot 0 not issued on memory unit");
  a_illegal_tmpl: assert property (s_take_ok ##0 !legal |-> ##2
    illegal_tmpl_ff && !issue_ff.valid) else $error("illegal template not flagged");
  a_slot_order: assert property (issue_ff.valid && issue_ff.slot == 2'd0 |=>
    issue_ff.valid && issue_ff.slot == 2'd1) else $error("slot 1 not after slot 0");
  a_group_end: assert property (group_end_ff == (issue_ff.valid && issue_ff.stop))
    else $error("group end differs from stop");
  a_phase_read: assert property (phase_ff[1] == issue_ff.valid)
    else $error("read phase differs from issue");
  a_phase_chain: assert property (phase_ff[1] |=> phase_ff[2] ##1 phase_ff[3])
    else $error("execute or update phase missing");
  a_ext_pair: assert property (issue_ff.valid && issue_ff.extended |->
    issue_ff.slot == 2'd1 && issue_ff.itype == BTD_ITYPE_LX &&
    (issue_ff.unit == BTD_UNIT_I || issue_ff.unit == BTD_UNIT_B))
    else $error("extended issue malformed");
endmodule : btd_checker

bind btd_decoder btd_checker i_checker (
  .sys_clk(sys_clk), .reset(reset), .bundle_valid(bundle_valid),
  .bundle_data(bundle_data), .bundle_addr(bundle_addr),
  .bundle_ready_ff(bundle_ready_ff), .data_big_endian_select(data_big_endian_select),
  .issue_ff(issue_ff), .group_end_ff(group_end_ff), .phase_ff(phase_ff),
  .misaligned_ff(misaligned_ff), .illegal_tmpl_ff(illegal_tmpl_ff)
);
`default_nettype wire

// >>> sim/btd_fetch_model.sv
// Fetch-side model: offers one bundle at a time on the valid/ready port.
// Assumes offer is called at a falling edge of the clock.
`timescale 1ns/1ps
`default_nettype none
`include "btd_cfg.svh"

module btd_fetch_model (
  // Clock and flow control
  input  wire logic                    clk,
  input  wire logic                    ready,
  // Bundle toward the decoder
  output var logic                     valid,
  output var logic [`BTD_BUNDLE_W-1:0] data,
  output var logic [`BTD_ADDR_W-1:0]   addr
);
  initial begin
    valid = 1'b0;
    data  = '0;
    addr  = '0;
  end

  // Hold the offer for up to 16 rising edges, until ready is seen high at one
  task automatic offer(input logic [127:0] d, input logic [63:0] a, output logic ok);
    ok    = 1'b0;
    valid = 1'b1;
    data  = d;
    addr  = a;
    for (int c = 0; c < 16 && !ok; c++) begin
      // Ready is settled at the falling edge and stands at the next rising one,
      // so the offer is released at the falling edge after the edge that took it
      ok = (ready === 1'b1);
      @(posedge clk);
      if (!ok) begin
        @(negedge clk);
      end
    end
    @(negedge clk);
    valid = 1'b0;
    // Released lines show the inverse so stale data cannot match
    data  = ~d;
    addr  = ~a;
  endtask : offer
endmodule : btd_fetch_model
`default_nettype wire

// >>> sim/bundle_template_decoder_test.sv
// Testbench of the bundle decoder: one task per scenario, then a verdict.
// Assumes the fetch model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "btd_cfg.svh"
`define BTD_CHK(got, exp, msg) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED at %0t: %s", $time, msg); \
    end \
  end

module bundle_template_decoder_test
  import btd_pkg::*;
;
  logic                     sys_clk = 1'b0;
  logic                     reset   = 1'b1;
  logic                     endian_sel = 1'b0;
  logic                     bundle_valid;
  logic [`BTD_BUNDLE_W-1:0] bundle_data;
  logic [`BTD_ADDR_W-1:0]   bundle_addr;
  logic                     bundle_ready_ff;
  btd_issue_s               issue_ff;
  logic                     group_end_ff;
  logic [`BTD_PHASES-1:0]   phase_ff;
  logic                     misaligned_ff;
  logic                     illegal_tmpl_ff;
  logic [63:0]              next_addr = 64'h0000_0000_0001_0000;
  logic                     ok;
  int                       error_cnt = 0;
  int                       cmp_count = 0;

  // 10 MHz clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  btd_decoder i_dut (
    .sys_clk(sys_clk), .reset(reset), .bundle_valid(bundle_valid),
    .bundle_data(bundle_data), .bundle_addr(bundle_addr),
    .bundle_ready_ff(bundle_ready_ff), .data_big_endian_select(endian_sel),
    .issue_ff(issue_ff), .group_end_ff(group_end_ff), .phase_ff(phase_ff),
    .misaligned_ff(misaligned_ff), .illegal_tmpl_ff(illegal_tmpl_ff));
  btd_fetch_model i_fetch (.clk(sys_clk), .ready(bundle_ready_ff),
    .valid(bundle_valid), .data(bundle_data), .addr(bundle_addr));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // Offer one bundle, collect its issues, compare each field
  task automatic run_bundle(input logic [4:0] tmpl, input logic [3:0] xop);
    logic [40:0] s [3];
    logic [5:0]  u [3];
    logic [2:0]  it [3];
    logic        ext;
    int          n;
    int          got;
    // High major opcodes on some templates make ALU work on M and I slots
    s[0] = {tmpl[0] ? 4'h9 : 4'h0, 37'h0_0000_0A01};
    s[1] = {tmpl[1] ? 4'hA : 4'h0, 37'h0_0000_0B02};
    s[2] = {xop, 37'h0_0000_0C03};
    ext  = (tmpl == 5'h04) || (tmpl == 5'h05);
    n    = ext ? 2 : 3;
    got  = 0;
    u[0] = BTD_UNIT_M;
    u[1] = (tmpl >= 5'h08) ? BTD_UNIT_M : BTD_UNIT_I;
    u[2] = BTD_UNIT_I;
    if (ext && (xop == 4'hC || xop == 4'hD)) begin
      u[1] = BTD_UNIT_B;
    end
    // Expected type: ALU from opcode 8 up, else the slot's own kind
    for (int k = 0; k < 3; k++) begin
      it[k] = (s[k][40:37] >= 4'h8) ? BTD_ITYPE_A :
              (u[k] == BTD_UNIT_M) ? BTD_ITYPE_M : BTD_ITYPE_I;
    end
    if (ext) begin
      it[1] = BTD_ITYPE_LX;
    end
    // Endian select flips every bundle and must change nothing
    endian_sel = ~endian_sel;
    i_fetch.offer({s[2], s[1], s[0], tmpl}, next_addr, ok);
    `BTD_CHK(ok, 1'b1, "bundle not taken")
    for (int c = 0; c < 8 && got < n; c++) begin
      @(negedge sys_clk);
      if (issue_ff.valid === 1'b1) begin
        `BTD_CHK(issue_ff.insn, (ext && got == 1) ? {s[2], s[1]} : {41'h0, s[got]}, "insn")
        `BTD_CHK(issue_ff.slot, 2'(got), "slot order")
        `BTD_CHK(issue_ff.unit, u[got], "unit type")
        `BTD_CHK(issue_ff.stop, tmpl == 5'h03 && got > 0, "stop position")
        `BTD_CHK(issue_ff.extended, ext && got == 1, "extended flag")
        `BTD_CHK(issue_ff.addr, next_addr, "bundle order")
        `BTD_CHK(issue_ff.itype, it[got], "insn type")
        `BTD_CHK(group_end_ff, tmpl == 5'h03 && got > 0, "group end")
        `BTD_CHK(phase_ff[1], 1'b1, "read phase")
        got++;
      end
    end
    `BTD_CHK(got, n, "issue count")
    if (got != n) begin
      print_verdict();
    end
    next_addr = next_addr + 64'h10;
  endtask : run_bundle

  task automatic t_mii_stops();
    for (int t = 0; t < 4; t++) run_bundle(5'(t), 4'h0);
  endtask : t_mii_stops

  task automatic t_mmi_units();
    for (int t = 8; t < 11; t++) run_bundle(5'(t), 4'h0);
  endtask : t_mmi_units

  task automatic t_extended();
    run_bundle(5'h04, 4'h0);
    run_bundle(5'h05, 4'hC);
    run_bundle(5'h04, 4'hD);
  endtask : t_extended

  task automatic t_misaligned();
    i_fetch.offer(128'h0, next_addr + 64'h4, ok);
    // The refusal pulse stands only in the cycle after the take
    `BTD_CHK(ok, 1'b1, "misaligned bundle not taken")
    `BTD_CHK(misaligned_ff, 1'b1, "misaligned flag")
    `BTD_CHK(bundle_ready_ff, 1'b1, "ready after refusal")
    repeat (3) begin
      @(negedge sys_clk);
      `BTD_CHK(issue_ff.valid, 1'b0, "refused bundle issued")
    end
  endtask : t_misaligned

  task automatic t_illegal();
    logic [4:0] bad [3] = '{5'h06, 5'h07, 5'h0B};
    for (int i = 0; i < 3; i++) begin
      i_fetch.offer({123'h0, bad[i]}, next_addr, ok);
      `BTD_CHK(ok, 1'b1, "illegal bundle not taken")
      @(negedge sys_clk);
      `BTD_CHK(illegal_tmpl_ff, 1'b1, "illegal flag")
      `BTD_CHK(issue_ff.valid, 1'b0, "illegal bundle issued")
    end
  endtask : t_illegal

  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    t_mii_stops();
    t_mmi_units();
    t_extended();
    t_misaligned();
    t_illegal();
    t_mii_stops();
    print_verdict();
  end
endmodule : bundle_template_decoder_test
`default_nettype wire
